// File: verilog/uart_rx_filter_end.sv
// Oversampling serial receiver with multi-processor address filter and AXI4-Lite registers.
// Behaviour
// RULE1: 16 samples per bit, 8 in double speed.
// RULE2: vote starts at sample 8, or 4.
// RULE3: vote centre is sample 9, or 5.
// RULE4: data plus parity spans 5 to 10 bits.
// RULE5: filter on drops non-address frames unbuffered.
// RULE6: type bit: first stop, or ninth bit.
// RULE7: type one is address, zero is data.
// RULE8: filter never touches the transmit side.
// RULE9: master sends ninth bit as frame type.
// RULE10: accepted address frame buffered and flagged normally.
// RULE11: filter off accepts every data frame.
// RULE12: slave software re-arms filter after last frame.
// RULE13: short frames need two stop bits.
// RULE14: one character size for transmit and receive.
// RULE15: software avoids read-modify-write on filter bit.
// RULE16: received ninth bit readable beside the data.
`timescale 1ns/10ps
module uart_rx_filter_end
  import serial_mp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   irq,
  output logic [2:0]             char_size_sel,
  serial_mp_if.device            lnk
);
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
    $error("ADDR_W must lie between 5 and 8.");
  end

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_e;

  function automatic logic majority(input logic a, input logic b, input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction

  logic [CTRL_W-1:0] ctrl_reg;
  logic [BAUD_W-1:0] baud_reg;
  logic [BAUD_W-1:0] baud_cnt_reg;
  logic [EV_W-1:0]   status_reg;
  logic [EV_W-1:0]   mask_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic [8:0]        rx_buf_reg;
  logic              rx_ninth_bit;
  logic              rx_complete_flag;
  rx_state_e         state_reg;
  logic [4:0]        samp_reg;
  logic [3:0]        bit_idx_reg;
  logic [MAX_D-1:0]  bits_reg;
  logic              v1_reg;
  logic              v2_reg;

  logic       rx_en;
  logic       double_speed_sel;
  logic       parity_en;
  logic       multiproc_filter_bit;
  logic [4:0] spb;
  logic [4:0] vote_first;
  logic [4:0] vote_mid;
  logic [3:0] ndata;
  logic [3:0] nbits;
  logic       tick;
  logic       vote_at;
  logic       vote;
  logic       nine;
  logic       frame_done;
  logic       frame_type;
  logic       store;
  logic       overrun;
  logic [8:0] rx_word;
  logic       rd_take;
  logic       rd_pop;
  logic       do_write;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic [31:0]     rd_data;
  logic            rd_hit;

  assign rx_en                = ctrl_reg[CTRL_RX_EN_BIT];
  assign double_speed_sel     = ctrl_reg[CTRL_DSPEED_BIT];
  assign parity_en            = ctrl_reg[CTRL_PARITY_BIT];
  assign multiproc_filter_bit = ctrl_reg[CTRL_FILTER_BIT];
  // The character size leaves the block so the local transmitter shares it;
  // the filter bit deliberately does not.
  assign char_size_sel = ctrl_reg[CTRL_CSIZE_LSB +: 3]; // see RULE14 see RULE8

  assign spb        = double_speed_sel ? SPB_DOUBLE : SPB_NORMAL; // see RULE1
  assign vote_first = double_speed_sel ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL; // see RULE2
  assign vote_mid   = double_speed_sel ? VOTE_MID_DOUBLE : VOTE_MID_NORMAL; // see RULE3
  assign ndata      = data_bits(char_size_sel);
  assign nbits      = 4'(ndata + {3'h0, parity_en}); // see RULE4
  assign nine       = (char_size_sel == CHAR_SIZE_NINE);

  assign tick    = rx_en && (baud_cnt_reg == baud_reg);
  assign vote_at = tick && (state_reg != RX_IDLE) && (samp_reg == 5'(vote_mid + 5'h01));
  assign vote    = majority(v1_reg, v2_reg, lnk.line);

  assign frame_done = vote_at && (state_reg == RX_STOP);
  assign frame_type = nine ? bits_reg[8] : vote; // see RULE6 see RULE9 see RULE13
  // A set type bit marks an address; with the filter clear every frame passes.
  assign store   = frame_done && (!multiproc_filter_bit || frame_type); // see RULE5 see RULE7 see RULE11
  assign rx_word = bits_reg[8:0] & 9'((10'h001 << ndata) - 10'h001);
  assign rd_take = arvalid && arready;
  assign rd_pop  = rd_take && (araddr == ADDR_W'(RXDATA_OFS));
  assign overrun = store && rx_complete_flag && !rd_pop;

  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_en || tick) begin
      baud_cnt_reg <= '0;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 16'h0001;
    end
  end

  // Sample 1 is the first low sample; votes use the three samples around the centre.
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_en) begin
      state_reg   <= RX_IDLE;
      samp_reg    <= 5'h00;
      bit_idx_reg <= 4'h0;
      bits_reg    <= '0;
      v1_reg      <= 1'b0;
      v2_reg      <= 1'b0;
    end else if (tick) begin
      samp_reg <= (samp_reg == spb) ? 5'h01 : 5'(samp_reg + 5'h01); // see RULE1
      if (samp_reg == vote_first) begin
        v1_reg <= lnk.line; // see RULE2
      end
      if (samp_reg == vote_mid) begin
        v2_reg <= lnk.line; // see RULE3
      end
      case (state_reg)
        RX_IDLE: begin
          // The first low tick is sample 1, so the following tick must count as sample 2.
          if (!lnk.line) begin
            state_reg <= RX_START;
            samp_reg  <= 5'h02; // see RULE2 see RULE3
          end else begin
            samp_reg <= 5'h01;
          end
        end
        RX_START: begin
          if (vote_at && vote) begin
            state_reg <= RX_IDLE;
          end else if (samp_reg == spb) begin
            state_reg   <= RX_DATA;
            bit_idx_reg <= 4'h0;
          end
        end
        RX_DATA: begin
          if (vote_at) begin
            bits_reg[bit_idx_reg] <= vote;
          end
          if (samp_reg == spb) begin
            bit_idx_reg <= 4'(bit_idx_reg + 4'h1);
            if (bit_idx_reg == 4'(nbits - 4'h1)) begin
              state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          // Ending at the stop vote lets the next start bit be seen early.
          if (vote_at) begin
            state_reg <= RX_IDLE;
          end
        end
        default: state_reg <= RX_IDLE;
      endcase
    end
  end

  // A frame landing in the cycle the buffer is read is kept, not lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_reg       <= 9'h000;
      rx_ninth_bit     <= 1'b0;
      rx_complete_flag <= 1'b0;
    end else if (!rx_en) begin
      rx_complete_flag <= 1'b0;
    end else if (store && (!rx_complete_flag || rd_pop)) begin
      rx_buf_reg       <= rx_word; // see RULE10
      rx_ninth_bit     <= nine && bits_reg[8]; // see RULE16
      rx_complete_flag <= 1'b1; // see RULE10
    end else if (rd_pop) begin
      rx_complete_flag <= 1'b0;
    end
  end

  assign do_write = !awready && !wready && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      waddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready   <= 1'b0;
        waddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wready    <= 1'b0;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        if (waddr_reg == ADDR_W'(CTRL_OFS) || waddr_reg == ADDR_W'(BAUD_OFS) ||
            waddr_reg == ADDR_W'(STATUS_OFS) || waddr_reg == ADDR_W'(MASK_OFS)) begin
          bresp <= RESP_OKAY;
        end else begin
          bresp <= RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // The filter bit is a plain control bit here; no flag shares its word.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      baud_reg <= BAUD_RESET;
      mask_reg <= '0;
    end else if (do_write) begin
      if (waddr_reg == ADDR_W'(CTRL_OFS) && wstrb_reg[0]) begin
        ctrl_reg <= wdata_reg[CTRL_W-1:0]; // see RULE12 see RULE15
      end else if (waddr_reg == ADDR_W'(BAUD_OFS)) begin
        if (wstrb_reg[0]) begin
          baud_reg[7:0] <= wdata_reg[7:0];
        end
        if (wstrb_reg[1]) begin
          baud_reg[15:8] <= wdata_reg[15:8];
        end
      end else if (waddr_reg == ADDR_W'(MASK_OFS) && wstrb_reg[0]) begin
        mask_reg <= wdata_reg[EV_W-1:0];
      end
    end
  end

  assign ev_set[EV_FRAME]   = store;
  assign ev_set[EV_ADDR]    = store && frame_type;
  assign ev_set[EV_OVERRUN] = overrun;
  assign ev_clr = (do_write && waddr_reg == ADDR_W'(STATUS_OFS) && wstrb_reg[0]) ?
                  wdata_reg[EV_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
      irq        <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~ev_clr) | ev_set;
      irq        <= |(((status_reg & ~ev_clr) | ev_set) & mask_reg);
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (araddr == ADDR_W'(CTRL_OFS)) begin
      rd_data[CTRL_W-1:0] = ctrl_reg;
    end else if (araddr == ADDR_W'(BAUD_OFS)) begin
      rd_data[BAUD_W-1:0] = baud_reg;
    end else if (araddr == ADDR_W'(RXDATA_OFS)) begin
      rd_data[8:0]                = rx_buf_reg;
      rd_data[RXDATA_NINTH_BIT]   = rx_ninth_bit; // see RULE16
      rd_data[RXDATA_FULL_BIT]    = rx_complete_flag;
    end else if (araddr == ADDR_W'(STATUS_OFS)) begin
      rd_data[EV_W-1:0]       = status_reg;
      rd_data[STATUS_BUSY_BIT] = (state_reg != RX_IDLE);
    end else if (araddr == ADDR_W'(MASK_OFS)) begin
      rd_data[EV_W-1:0] = mask_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (rd_take) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_data;
      rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end
endmodule

// File: verilog/serial_mp_pkg.sv
// Shared constants and helpers for the multi-processor serial link.
package serial_mp_pkg;
  localparam logic [4:0] SPB_NORMAL        = 5'h10;
  localparam logic [4:0] SPB_DOUBLE        = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [4:0] VOTE_MID_NORMAL   = 5'h09;
  localparam logic [4:0] VOTE_MID_DOUBLE   = 5'h05;
  localparam logic [2:0] CHAR_SIZE_NINE    = 3'h7;
  localparam int         MAX_D             = 10;
  localparam int         FRAME_W           = 13;
  localparam int         BAUD_W            = 16;

  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] BAUD_OFS   = 8'h04;
  localparam logic [7:0] RXDATA_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] MASK_OFS   = 8'h10;

  localparam int CTRL_RX_EN_BIT  = 0;
  localparam int CTRL_DSPEED_BIT = 1;
  localparam int CTRL_CSIZE_LSB  = 2;
  localparam int CTRL_PARITY_BIT = 5;
  localparam int CTRL_FILTER_BIT = 6;
  localparam int CTRL_W          = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 16'h0000;

  localparam int EV_FRAME   = 0;
  localparam int EV_ADDR    = 1;
  localparam int EV_OVERRUN = 2;
  localparam int EV_W       = 3;
  localparam int STATUS_BUSY_BIT  = 3;
  localparam int RXDATA_NINTH_BIT = 8;
  localparam int RXDATA_FULL_BIT  = 31;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Data bits per character for a character-size code; unused codes act as 8.
  function automatic logic [3:0] data_bits(input logic [2:0] sel);
    case (sel)
      3'h0:    data_bits = 4'h5;
      3'h1:    data_bits = 4'h6;
      3'h2:    data_bits = 4'h7;
      3'h7:    data_bits = 4'h9;
      default: data_bits = 4'h8;
    endcase
  endfunction
endpackage

// File: verilog/serial_mp_if.sv
// Shared serial line between the master transmitter and a filtering receiver.
`timescale 1ns/10ps
interface serial_mp_if;
  logic line;
  modport device (input line);
  modport master (output line);
endinterface

// File: verilog/uart_mp_master_end.sv
// Master transmitter that marks each frame as address or data for the shared line.
`timescale 1ns/10ps
module uart_mp_master_end
  import serial_mp_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [BAUD_W-1:0] baud_div,
  input  wire logic              double_speed_sel,
  input  wire logic [2:0]        char_size_sel,
  input  wire logic              parity_en,
  input  wire logic              two_stop_sel,
  input  wire logic              tx_valid,
  input  wire logic [7:0]        tx_data,
  input  wire logic              tx_ninth_bit,
  output logic                   tx_ready,
  output logic                   tx_complete_flag,
  serial_mp_if.master            lnk
);
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_BUSY = 2'b10
  } tx_state_e;

  tx_state_e          state_reg;
  logic [FRAME_W-1:0] frame_reg;
  logic [3:0]         left_reg;
  logic [4:0]         samp_reg;
  logic [BAUD_W-1:0]  cnt_reg;
  logic               line_reg;

  logic               nine;
  logic [3:0]         ndata;
  logic [4:0]         spb;
  logic               tick;
  logic               take;
  logic [8:0]         dword;
  logic [3:0]         pos;
  logic [2:0]         tail;
  logic               stop1;
  logic               stop2_on;
  logic [FRAME_W-1:0] frame_next;
  logic [3:0]         nbits;

  assign nine  = (char_size_sel == CHAR_SIZE_NINE);
  assign ndata = data_bits(char_size_sel);
  assign spb   = double_speed_sel ? SPB_DOUBLE : SPB_NORMAL;
  assign tick  = (cnt_reg == baud_div);
  assign take  = tx_valid && tx_ready;
  // In nine-bit frames the ninth data bit carries the type; otherwise the first stop bit does.
  assign dword = {nine & tx_ninth_bit, tx_data} & 9'((10'h001 << ndata) - 10'h001); // see RULE9
  assign stop1 = nine ? 1'b1 : tx_ninth_bit;
  // A real stop bit must follow the type bit, so short frames always send two.
  assign stop2_on = two_stop_sel || !nine; // see RULE13
  assign pos   = 4'(ndata + 4'h1);
  assign tail  = parity_en ? {1'b1, stop1, ^dword} : {1'b1, 1'b1, stop1};
  assign nbits = 4'(pos + {3'h0, parity_en} + 4'h1 + {3'h0, stop2_on});

  always_comb begin
    frame_next = {{(FRAME_W-10){1'b1}}, dword, 1'b0};
    frame_next = (frame_next & ~(FRAME_W'(3'h7) << pos)) | (FRAME_W'(tail) << pos);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || take || tick) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg        <= TX_IDLE;
      frame_reg        <= '1;
      left_reg         <= 4'h0;
      samp_reg         <= 5'h01;
      tx_ready         <= 1'b1;
      tx_complete_flag <= 1'b0;
      line_reg         <= 1'b1;
    end else begin
      tx_complete_flag <= 1'b0;
      line_reg         <= (state_reg == TX_BUSY) ? frame_reg[0] : 1'b1;
      case (state_reg)
        TX_IDLE: begin
          if (take) begin
            state_reg <= TX_BUSY;
            frame_reg <= frame_next;
            left_reg  <= nbits;
            samp_reg  <= 5'h01;
            tx_ready  <= 1'b0;
          end
        end
        TX_BUSY: begin
          if (tick) begin
            samp_reg <= 5'(samp_reg + 5'h01);
            if (samp_reg == spb) begin
              samp_reg  <= 5'h01;
              frame_reg <= {1'b1, frame_reg[FRAME_W-1:1]};
              left_reg  <= 4'(left_reg - 4'h1);
              if (left_reg == 4'h1) begin
                state_reg        <= TX_IDLE;
                tx_ready         <= 1'b1;
                tx_complete_flag <= 1'b1;
              end
            end
          end
        end
        default: state_reg <= TX_IDLE;
      endcase
    end
  end

  assign lnk.line = line_reg;
endmodule

// File: test/uart_rx_multiproc_filter_asserts.sv
// Checker for the register handshake, the master's line and the interrupt output.
`timescale 1ns/10ps
module uart_rx_multiproc_filter_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        line,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        tx_complete_flag,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_tx_idle_line: assert property (tx_ready |-> line)
    else $error("line low while master idle");
  chk_tx_start_bit: assert property (tx_valid && tx_ready |=> !tx_ready ##[0:2] !line)
    else $error("no start bit after accepted frame");
  chk_done_pulse: assert property (tx_complete_flag |=> !tx_complete_flag)
    else $error("completion flag longer than one cycle");
  chk_b_answer: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write response late or early");
  chk_b_holds: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  chk_write_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  chk_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  chk_r_stable: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed while waiting");
  chk_read_refused: assert property (rvalid |-> !arready)
    else $error("read accepted while data pending");
  // Status bits are sticky, so only a register write may lower the interrupt.
  chk_irq_sticky: assert property (irq && awready |=> irq)
    else $error("interrupt fell without a write");

  cover property (bvalid && bready);
  cover property (rvalid && rready);
  cover property (tx_complete_flag);
  cover property ($rose(irq));
endmodule

// File: test/uart_rx_multiproc_filter_tb.sv
// Self-checking bench joining the master transmitter and the filtering receiver.
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module uart_rx_multiproc_filter_tb;
  import serial_mp_pkg::*;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic              tx_valid, tx_ready, tx_complete_flag, tx_ninth_bit;
  logic              double_speed_sel, parity_en, two_stop_sel;
  logic [7:0]        awaddr, araddr, tx_data, dd, aa;
  logic [31:0]       wdata, rdata, cfg, m;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [2:0]        char_size_sel, sz;
  logic [4:0]        mode;
  logic [8:0]        dm;
  logic [BAUD_W-1:0] baud_div;
  int                n_fail, n_tests, i;

  serial_mp_if lnk ();
  uart_rx_filter_end uart_rx_filter_end_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .irq, .char_size_sel, .lnk(lnk));
  // Both ends share one size setting, as a single channel would.
  uart_mp_master_end uart_mp_master_end_i (.aclk, .aresetn, .baud_div, .double_speed_sel,
    .char_size_sel, .parity_en, .two_stop_sel, .tx_valid, .tx_data, .tx_ninth_bit,
    .tx_ready, .tx_complete_flag, .lnk(lnk));
  uart_rx_multiproc_filter_asserts uart_rx_multiproc_filter_asserts_i (.aclk, .aresetn,
    .line(lnk.line), .tx_valid, .tx_ready, .tx_complete_flag, .awvalid, .awready, .wvalid,
    .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata, .irq);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang;
    n_fail++;
    $display("BAD %0t timeout", $time);
    wrap_up;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && k < 400);
    bready <= 1'b0;
    if (!bvalid) hang;
    `CHK(bresp, er)
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] msk,
                      input logic [1:0] er = RESP_OKAY);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && k < 400);
    rready <= 1'b0;
    if (!rvalid) hang;
    `CHK(rdata & msk, e)
    `CHK(rresp, er)
  endtask

  // Returns once the master reports the frame done; the receiver stores it earlier.
  task automatic send(input logic [7:0] d, input logic n);
    int k;
    k = 0;
    @(posedge aclk);
    tx_data <= d;
    tx_ninth_bit <= n;
    tx_valid <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
    end while (!tx_ready && k < 400);
    tx_valid <= 1'b0;
    if (!tx_ready) hang;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (!tx_complete_flag && k < 2000);
    if (!tx_complete_flag) hang;
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, tx_valid, tx_ninth_bit} = '0;
    {double_speed_sel, parity_en, two_stop_sel} = '0;
    {awaddr, araddr, tx_data, wdata} = '0;
    wstrb = 4'hf;
    baud_div = 16'h0001;
    n_fail = 0;
    n_tests = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(CTRL_OFS, 32'h0, 32'h7f);
    rchk(BAUD_OFS, 32'h0, 32'hffff);
    rchk(STATUS_OFS, 32'h0, 32'hf);
    rchk(MASK_OFS, 32'h0, 32'h7);
    rchk(8'h20, 32'h0, 32'hffffffff, RESP_SLVERR);
    wr(8'h20, 32'hff, RESP_SLVERR);
    wr(BAUD_OFS, 32'h1);
    wr(MASK_OFS, 32'h2);
    rchk(MASK_OFS, 32'h2, 32'h7);
    // Each mode is {parity, double speed, size code}; covers D = 5, 9, 10 and 9.
    for (i = 0; i < 4; i++) begin
      mode = (i == 0) ? 5'h00 : (i == 1) ? 5'h1b : (i == 2) ? 5'h17 : 5'h0f;
      sz = mode[2:0];
      double_speed_sel <= mode[3];
      parity_en <= mode[4];
      two_stop_sel <= mode[3];
      cfg = 32'h1 | {26'h0, mode[4], sz, mode[3], 1'b0};
      dm = (sz == 3'h7) ? 9'h1ff : ((9'h1 << (4'(sz) + 4'h5)) - 9'h1);
      m = 32'h8000_0000 | ((sz == 3'h7) ? 32'h1ff : 32'hff);
      dd = 8'h5a + 8'(i);
      aa = 8'hc3 - 8'(i);
      wr(CTRL_OFS, cfg | 32'h40);
      `CHK(char_size_sel, sz)
      wr(STATUS_OFS, 32'h7);
      send(dd, 1'b0);
      rchk(STATUS_OFS, 32'h0, 32'h7);
      `CHK(irq, 1'b0)
      send(aa, 1'b1);
      rchk(STATUS_OFS, 32'h3, 32'h7);
      `CHK(irq, 1'b1)
      rchk(RXDATA_OFS, 32'h8000_0000 | {23'h0, {1'b1, aa} & dm}, m);
      wr(CTRL_OFS, cfg);
      wr(STATUS_OFS, 32'h7);
      rchk(STATUS_OFS, 32'h0, 32'h7);
      `CHK(irq, 1'b0)
      send(dd, 1'b0);
      rchk(STATUS_OFS, 32'h1, 32'h7);
      rchk(RXDATA_OFS, 32'h8000_0000 | {23'h0, {1'b0, dd} & dm}, m);
    end
    // A second frame arriving while the first is unread is dropped, the first is kept.
    wr(STATUS_OFS, 32'h7);
    send(8'h11, 1'b0);
    send(8'h22, 1'b0);
    rchk(STATUS_OFS, 32'h5, 32'h7);
    rchk(RXDATA_OFS, 32'h8000_0011, m);
    wrap_up;
  end
endmodule
